/* rtl/dual_adc_serial_port.sv */
// dual converter sequencing, serial result readout and serial configuration
// Overview of operation
// - trigger rise holds inputs, next edge converts
// - busy high in hold until conversion done
// - read strobe frames transfers only when selected
// - result output a driven when select low
// - each converter own output, valid falling edge
// - lane select high drives both outputs
// - channel mode pin assigns channels to converters
// - config input works extended or legacy
// - early trigger during hold or conversion is ignored
// - channel select from two config bits
`timescale 1ns/100ps
module dual_adc_serial_port
    import dual_adc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        conversion_trigger_i,
    input  wire logic        select_n_i,
    input  wire logic        read_strobe_i,
    input  wire logic        serial_config_in_i,
    input  wire logic        output_lane_select_i,
    input  wire logic        channel_mode_select_i,
    output logic             converter_a_serial_out_o,
    output logic             converter_a_serial_oe_n_o,
    output logic             converter_b_serial_out_o,
    output logic             converter_b_serial_oe_n_o,
    output logic             busy_o,
    output logic             channel_select_hi_o,
    output logic             channel_select_lo_o,
    output logic             channel_mode_o,
    output logic             sample_hold_o,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o
);
    conv_state_t state;
    conv_state_t next_state;

    // pin synchronisers: first stage feeds only the second
    logic [1:0] trig_sync;
    logic [1:0] sel_sync;
    logic [1:0] rd_sync;
    logic [1:0] sdi_sync;
    logic [1:0] lane_sync;
    logic [1:0] mode_sync;
    logic       trig_prev;
    logic       rd_prev;
    logic       trig_rise;
    logic       rd_rise;
    logic       selected;

    logic [4:0]  conv_cnt;
    logic [11:0] sar_a;
    logic [11:0] sar_b;
    logic [11:0] shift_a;
    logic [11:0] shift_b;
    logic [3:0]  read_cnt;
    logic        reading;
    logic [15:0] cfg_shift;
    logic [4:0]  cfg_cnt;
    logic        cfg_active;
    logic [15:0] cfg_word;
    logic        conv_done;
    logic        cfg_done;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [11:0] sample_a;
    logic [11:0] sample_b;
    logic        soft_trigger;
    logic        legacy_mode;
    logic        store_rd_sel;
    logic [11:0] store_rd_data;
    logic        wb_hit;
    logic        wb_wr;
    logic        wb_wait;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_sync <= 2'h0;
            sel_sync  <= 2'h3;
            rd_sync   <= 2'h0;
            sdi_sync  <= 2'h0;
            lane_sync <= 2'h0;
            mode_sync <= 2'h0;
        end
        else
        begin
            trig_sync <= {trig_sync[0], conversion_trigger_i};
            sel_sync  <= {sel_sync[0], select_n_i};
            rd_sync   <= {rd_sync[0], read_strobe_i};
            sdi_sync  <= {sdi_sync[0], serial_config_in_i};
            lane_sync <= {lane_sync[0], output_lane_select_i};
            mode_sync <= {mode_sync[0], channel_mode_select_i};
        end
    end

    // edge history on synchronised levels
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_prev <= 1'b0;
            rd_prev   <= 1'b0;
        end
        else
        begin
            trig_prev <= trig_sync[1];
            rd_prev   <= rd_sync[1];
        end
    end

    assign selected  = ~sel_sync[1];
    assign trig_rise = (trig_sync[1] & ~trig_prev) | soft_trigger;
    assign rd_rise   = rd_sync[1] & ~rd_prev & selected;

    // the pin trigger is sampled, so the sub-cycle 10 ns / 5 ns windows collapse
    // to a fixed two-flop latency; host placement still matters
    always_comb
    begin
        next_state = state;
        case (state)
            CONV_SAMPLE: if (trig_rise) next_state = CONV_HOLD;
            CONV_HOLD:   next_state = CONV_RUN;
            CONV_RUN:    if (conv_cnt == CONV_LAST) next_state = CONV_SAMPLE;
            default:     next_state = CONV_SAMPLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= CONV_SAMPLE;
        else
            state <= next_state;
    end

    // bit counter and successive approximation of both converters
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            conv_cnt <= 5'h00;
            sar_a    <= RESULT_RST;
            sar_b    <= RESULT_RST;
        end
        else if (state == CONV_HOLD)
        begin
            conv_cnt <= 5'h00;
            sar_a    <= RESULT_RST;
            sar_b    <= RESULT_RST;
        end
        else if (state == CONV_RUN)
        begin
            conv_cnt <= conv_cnt + 5'h01;
            if (conv_cnt < 5'(RESULT_BITS))
            begin
                sar_a[4'(RESULT_BITS - 1) - conv_cnt[3:0]] <=
                    sample_a[4'(RESULT_BITS - 1) - conv_cnt[3:0]];
                sar_b[4'(RESULT_BITS - 1) - conv_cnt[3:0]] <=
                    sample_b[4'(RESULT_BITS - 1) - conv_cnt[3:0]];
            end
        end
    end

    // digital stand-in for the analog front end: a deterministic pattern
    assign sample_a = {cfg_word[11:2], channel_select_hi_o, channel_select_lo_o};
    assign sample_b = ~sample_a;

    assign conv_done = (state == CONV_RUN) && (conv_cnt == CONV_LAST);

    // busy covers hold and run
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_o        <= 1'b0;
            sample_hold_o <= 1'b0;
        end
        else
        begin
            busy_o        <= (next_state != CONV_SAMPLE);
            sample_hold_o <= (next_state != CONV_SAMPLE);
        end
    end

    // readout shifter, loaded at frame start, msb first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shift_a  <= RESULT_RST;
            shift_b  <= RESULT_RST;
            read_cnt <= 4'h0;
            reading  <= 1'b0;
        end
        else if (rd_rise)
        begin
            shift_a  <= sar_a;
            shift_b  <= sar_b;
            read_cnt <= 4'h0;
            reading  <= 1'b1;
        end
        else if (reading)
        begin
            shift_a  <= {shift_a[10:0], 1'b0};
            shift_b  <= {shift_b[10:0], 1'b0};
            read_cnt <= read_cnt + 4'h1;
            if (read_cnt == READ_LAST)
                reading <= 1'b0;
        end
    end

    // outputs change on the rising edge, stable by the falling edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            converter_a_serial_out_o  <= 1'b0;
            converter_b_serial_out_o  <= 1'b0;
            converter_a_serial_oe_n_o <= 1'b1;
            converter_b_serial_oe_n_o <= 1'b1;
        end
        else
        begin
            // lane low: a carries a only, b lane stays off
            converter_a_serial_out_o  <= shift_a[11];
            converter_b_serial_out_o  <= shift_b[11];
            converter_a_serial_oe_n_o <= ~selected;
            converter_b_serial_oe_n_o <= ~(selected & lane_sync[1]);
        end
    end

    // serial configuration capture, framed by the same strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_shift  <= 16'h0000;
            cfg_cnt    <= 5'h00;
            cfg_active <= 1'b0;
            cfg_word   <= 16'h0000;
        end
        else if (rd_rise)
        begin
            cfg_shift  <= {15'h0000, sdi_sync[1]};
            cfg_cnt    <= 5'h01;
            cfg_active <= 1'b1;
        end
        else if (cfg_active)
        begin
            cfg_shift <= {cfg_shift[14:0], sdi_sync[1]};
            cfg_cnt   <= cfg_cnt + 5'h01;
            // legacy use: only the two select bits are meaningful
            if (cfg_cnt == CFG_LAST)
            begin
                cfg_active <= 1'b0;
                cfg_word   <= legacy_mode ?
                    {cfg_shift[14:13], 14'h0000} : {cfg_shift[14:0], sdi_sync[1]};
            end
        end
    end

    assign cfg_done = cfg_active && (cfg_cnt == CFG_LAST);

    // channel routing
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            channel_select_hi_o <= 1'b0;
            channel_select_lo_o <= 1'b0;
            channel_mode_o      <= 1'b0;
        end
        else
        begin
            channel_select_hi_o <= cfg_word[CHSEL_HI_POS];
            channel_select_lo_o <= cfg_word[CHSEL_LO_POS];
            channel_mode_o      <= mode_sync[1];
        end
    end

    result_store u_store
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (conv_done),
        .wr_a_i    (sar_a),
        .wr_b_i    (sar_b),
        .rd_sel_i  (store_rd_sel),
        .rd_data_o (store_rd_data)
    );

    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // write lands once, at the edge that raises ack, so a soft trigger pulses once
    assign wb_wr  = wb_hit & wb_wait & wb_we_i & wb_sel_i[0];
    assign store_rd_sel = (wb_adr_i == ADR_RESULT_B);

    // control: soft trigger pulse and legacy flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            soft_trigger <= 1'b0;
            legacy_mode  <= 1'b0;
        end
        else
        begin
            soft_trigger <= wb_wr && (wb_adr_i == ADR_CTRL) && wb_dat_i[0];
            if (wb_wr && (wb_adr_i == ADR_CTRL))
                legacy_mode <= wb_dat_i[1];
        end
    end

    // sticky events; a set wins over a write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stat <= IRQ_RST;
        else
        begin
            if (wb_wr && (wb_adr_i == ADR_IRQ_STAT))
                irq_stat <= irq_stat & ~wb_dat_i[1:0];
            if (conv_done)
                irq_stat[IRQ_CONV_DONE] <= 1'b1;
            if (cfg_done)
                irq_stat[IRQ_CFG_DONE] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask <= IRQ_RST;
        else if (wb_wr && (wb_adr_i == ADR_IRQ_MASK))
            irq_mask <= wb_dat_i[1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_stat & irq_mask);
    end

    // ack two cycles after strobe so result memory read data is ready
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_wait  <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= UNMAPPED_DATA;
        end
        else
        begin
            wb_wait  <= wb_hit & ~wb_wait;
            wb_ack_o <= wb_hit & wb_wait;
            if (wb_hit & wb_wait)
            begin
                case (wb_adr_i)
                    ADR_CTRL:     wb_dat_o <= {30'h0, legacy_mode, 1'b0};
                    ADR_STATUS:   wb_dat_o <= {28'h0, reading, cfg_active, state};
                    ADR_RESULT_A: wb_dat_o <= {20'h0, store_rd_data};
                    ADR_RESULT_B: wb_dat_o <= {20'h0, store_rd_data};
                    ADR_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat};
                    ADR_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask};
                    ADR_CONFIG:   wb_dat_o <= {16'h0, cfg_word};
                    default:      wb_dat_o <= UNMAPPED_DATA;
                endcase
            end
        end
    end
endmodule

/* shared/dual_adc_pkg.sv */
// shared constants for the dual converter control and serial port
package dual_adc_pkg;
    localparam int unsigned RESULT_BITS   = 12;
    localparam int unsigned CONV_CYCLES   = 13;
    localparam int unsigned CFG_BITS      = 16;
    localparam logic [4:0]  CONV_LAST     = 5'h0c;
    localparam logic [3:0]  READ_LAST     = 4'hb;
    localparam logic [4:0]  CFG_LAST      = 5'h0f;
    localparam int unsigned CHSEL_HI_POS  = 15;
    localparam int unsigned CHSEL_LO_POS  = 14;
    localparam logic [31:0] ADR_CTRL      = 32'h0000_0000;
    localparam logic [31:0] ADR_STATUS    = 32'h0000_0004;
    localparam logic [31:0] ADR_RESULT_A  = 32'h0000_0008;
    localparam logic [31:0] ADR_RESULT_B  = 32'h0000_000c;
    localparam logic [31:0] ADR_IRQ_STAT  = 32'h0000_0010;
    localparam logic [31:0] ADR_IRQ_MASK  = 32'h0000_0014;
    localparam logic [31:0] ADR_CONFIG    = 32'h0000_0018;
    localparam logic [11:0] RESULT_RST    = 12'h000;
    localparam logic [1:0]  IRQ_RST       = 2'h0;
    localparam int unsigned IRQ_CONV_DONE = 0;
    localparam int unsigned IRQ_CFG_DONE  = 1;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0]
    {
        CONV_SAMPLE = 2'b00,
        CONV_HOLD   = 2'b01,
        CONV_RUN    = 2'b10
    } conv_state_t;
endpackage

/* rtl/result_store.sv */
// two-entry result memory with registered read data
`timescale 1ns/100ps
module result_store
    import dual_adc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_en_i,
    input  wire logic [11:0] wr_a_i,
    input  wire logic [11:0] wr_b_i,
    input  wire logic        rd_sel_i,
    output logic [11:0]      rd_data_o
);
    logic [11:0] mem [2];

    // one entry per converter
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem[0] <= RESULT_RST;
            mem[1] <= RESULT_RST;
        end
        else if (wr_en_i)
        begin
            mem[0] <= wr_a_i;
            mem[1] <= wr_b_i;
        end
    end

    // registered read port
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rd_data_o <= RESULT_RST;
        else
            rd_data_o <= mem[rd_sel_i];
    end
endmodule

/* dv/dual_adc_serial_port_asserts.sv */
// concurrent checks on the converter port pins and bus
`timescale 1ns/100ps
module dual_adc_serial_port_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic conversion_trigger_i,
    input wire logic select_n_i,
    input wire logic channel_mode_select_i,
    input wire logic converter_a_serial_oe_n_o,
    input wire logic converter_b_serial_oe_n_o,
    input wire logic busy_o,
    input wire logic sample_hold_o,
    input wire logic channel_mode_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus answer: single pulse, inside a request, soon
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("stray ack");
    a_ack_time: assert property ($rose(wb_stb_i) |-> ##[1:3] wb_ack_o) else $error("ack late");
    // sync latency bounds the trigger to busy delay
    a_trig_busy: assert property ($rose(conversion_trigger_i) && !busy_o |-> ##[2:6] busy_o)
        else $error("trigger did not start");
    a_busy_min: assert property ($rose(busy_o) |-> busy_o[*8]) else $error("busy short");
    a_busy_end: assert property ($rose(busy_o) |-> ##[13:16] !busy_o) else $error("busy stuck");
    a_hold_busy: assert property (sample_hold_o == busy_o) else $error("hold off busy");
    a_lane_b: assert property (!converter_b_serial_oe_n_o |-> !converter_a_serial_oe_n_o)
        else $error("b lane alone");
    a_desel_hiz: assert property (select_n_i[*4] |-> converter_a_serial_oe_n_o
        && converter_b_serial_oe_n_o) else $error("driven while deselected");
    a_mode_pin: assert property ($stable(channel_mode_select_i)[*4]
        |-> channel_mode_o == channel_mode_select_i) else $error("mode pin lost");
endmodule
bind dual_adc_serial_port dual_adc_serial_port_asserts dual_adc_serial_port_asserts_inst (
    .clk_i, .rst_i, .conversion_trigger_i, .select_n_i, .channel_mode_select_i,
    .converter_a_serial_oe_n_o, .converter_b_serial_oe_n_o, .busy_o, .sample_hold_o,
    .channel_mode_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* dv/host_ctrl_model.sv */
// behavioural host: trigger, select, strobe, config pins and capture
`timescale 1ns/100ps
module host_ctrl_model (
    input  wire logic clk_i,
    input  wire logic sdo_a_i,
    input  wire logic oe_a_n_i,
    input  wire logic sdo_b_i,
    input  wire logic oe_b_n_i,
    output logic      trig_o,
    output logic      select_n_o,
    output logic      strobe_o,
    output logic      cfg_o,
    output logic      lane_o,
    output logic      mode_o
);
    logic        last_a = 1'b0;
    logic        last_b = 1'b0;
    logic [23:0] cap_a  = 24'h0;
    logic [23:0] cap_b  = 24'h0;
    // released lines toggle so stale bits never pass for data
    wire         line_a = oe_a_n_i ? ~last_a : sdo_a_i;
    wire         line_b = oe_b_n_i ? ~last_b : sdo_b_i;
    initial {trig_o, select_n_o, strobe_o, cfg_o, lane_o, mode_o} = 6'h10;
    // results taken on the falling edge
    always @(negedge clk_i)
    begin
        last_a <= line_a;
        last_b <= line_b;
        cap_a  <= {cap_a[22:0], line_a};
        cap_b  <= {cap_b[22:0], line_b};
    end
    // pin is synced inside, so edge placement only shifts one cycle
    task convert();
        @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        trig_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // one frame; config word msb first from the strobe edge, one bit a clock,
    // so it lines up with the two-flop sync inside
    task read_frame(input logic sel, input logic [15:0] word, input logic lane,
                    output logic [23:0] a, output logic [23:0] b);
        @(posedge clk_i);
        select_n_o <= ~sel;
        lane_o     <= lane;
        repeat (4) @(posedge clk_i);
        strobe_o <= 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            cfg_o <= word[i];
            if (i == 13)
                strobe_o <= 1'b0;
            @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
        a = cap_a;
        b = cap_b;
        select_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

/* dv/dual_adc_serial_port_tb_top.sv */
// self-checking bench for the dual converter serial port
`timescale 1ns/100ps
module dual_adc_serial_port_tb_top;
    import dual_adc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        trig, sel_n, strobe, cfg, lane, mode;
    logic        sdo_a, oe_a_n, sdo_b, oe_b_n, busy, chs_hi, chs_lo, wb_ack, irq;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [31:0] wb_adr = 32'h0, wb_dat = 32'h0, wb_rd, rd, w;
    logic [23:0] fa, fb;
    logic [11:0] q_a[$];
    logic [15:0] exp_cfg = 16'h0;
    int          error_cnt = 0, checks = 0, cyc_cnt = 0, busy_cnt = 0, exp_irq;
    dual_adc_serial_port dual_adc_serial_port_inst (
        .clk_i(clk_i), .rst_i(rst_i), .conversion_trigger_i(trig), .select_n_i(sel_n),
        .read_strobe_i(strobe), .serial_config_in_i(cfg), .output_lane_select_i(lane),
        .channel_mode_select_i(mode), .converter_a_serial_out_o(sdo_a),
        .converter_a_serial_oe_n_o(oe_a_n), .converter_b_serial_out_o(sdo_b),
        .converter_b_serial_oe_n_o(oe_b_n), .busy_o(busy), .channel_select_hi_o(chs_hi),
        .channel_select_lo_o(chs_lo), .channel_mode_o(), .sample_hold_o(),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hf), .wb_we_i(wb_we),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .irq_o(irq));
    host_ctrl_model host_ctrl_model_inst (
        .clk_i(clk_i), .sdo_a_i(sdo_a), .oe_a_n_i(oe_a_n), .sdo_b_i(sdo_b),
        .oe_b_n_i(oe_b_n), .trig_o(trig), .select_n_o(sel_n), .strobe_o(strobe),
        .cfg_o(cfg), .lane_o(lane), .mode_o(mode));
    always #5 clk_i = ~clk_i;
    // cycle ceiling and busy length count
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        busy_cnt += busy;
        if (cyc_cnt == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask
    // classic cycle held until ack is sampled high
    task wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        @(posedge clk_i iff wb_ack);
        rd = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // frame alignment is loose, so look for the word anywhere
    function automatic logic has12(input logic [23:0] s, input logic [11:0] v);
        for (int i = 0; i <= 12; i++)
            if (s[i+:12] === v) return 1'b1;
        return 1'b0;
    endfunction
    initial
    begin
        void'($urandom(32'h7c0e));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        host_ctrl_model_inst.mode_o <= 1'($urandom);
        repeat (3) @(posedge clk_i);
        wb(0, ADR_RESULT_A, 0);
        chk(rd, {20'h0, RESULT_RST});
        wb(0, ADR_IRQ_STAT, 0);
        chk(rd, {30'h0, IRQ_RST});
        wb(0, 32'h0000_0020, 0);
        chk(rd, UNMAPPED_DATA);
        // config register is read-only: the word only arrives on the serial input
        w = $urandom & 32'hffff;
        wb(1, ADR_CONFIG, w);
        wb(0, ADR_CONFIG, 0);
        chk(rd, {16'h0, exp_cfg});
        chk({chs_hi, chs_lo}, exp_cfg[15:14]);
        $display("test registers done");
        // conversion with a retrigger mid-busy, irq masked and unmasked
        for (int m = 1; m >= 0; m--)
        begin
            wb(1, ADR_IRQ_MASK, m);
            busy_cnt = 0;
            host_ctrl_model_inst.convert();
            host_ctrl_model_inst.convert();
            q_a.push_back({exp_cfg[11:2], exp_cfg[15:14]});
            repeat (30) @(posedge clk_i);
            chk(busy_cnt inside {CONV_CYCLES + 1, CONV_CYCLES + 2}, 1);
            exp_irq = 1;
            wb(0, ADR_IRQ_STAT, 0);
            chk(rd, exp_irq);
            chk(irq, m);
            wb(0, ADR_RESULT_A, 0);
            chk(rd, {20'h0, q_a[$]});
            wb(0, ADR_RESULT_B, 0);
            chk(rd, {20'h0, ~q_a[$]});
            wb(1, ADR_IRQ_STAT, 1);
            exp_irq = 0;
            wb(0, ADR_IRQ_STAT, 0);
            chk(rd, exp_irq);
            chk(irq, 0);
        end
        $display("test conversion done");
        // frames over all lane and legacy settings, an unselected frame, then a conversion
        for (int k = 0; k < 4; k++)
        begin
            w = $urandom & 32'hffff;
            wb(1, ADR_CTRL, {30'h0, k[0], 1'b0});
            host_ctrl_model_inst.read_frame(1, w[15:0], k[1], fa, fb);
            chk(has12(fa, q_a[$]), 1);
            if (k[1]) chk(has12(fb, ~q_a[$]), 1);
            exp_cfg = k[0] ? {w[15:14], 14'h0} : w[15:0];
            chk({chs_hi, chs_lo}, exp_cfg[15:14]);
            wb(0, ADR_CONFIG, 0);
            chk(rd, {16'h0, exp_cfg});
            wb(0, ADR_IRQ_STAT, 0);
            chk(rd[IRQ_CFG_DONE], 1);
            wb(1, ADR_IRQ_STAT, 3);
            host_ctrl_model_inst.read_frame(0, ~w[15:0], k[1], fa, fb);
            chk({chs_hi, chs_lo}, exp_cfg[15:14]);
            wb(0, ADR_IRQ_STAT, 0);
            chk(rd, 0);
            if (k[1])
                wb(1, ADR_CTRL, {30'h0, k[0], 1'b1});
            else
                host_ctrl_model_inst.convert();
            q_a.push_back({exp_cfg[11:2], exp_cfg[15:14]});
            repeat (20) @(posedge clk_i);
            wb(0, ADR_RESULT_A, 0);
            chk(rd, {20'h0, q_a[$]});
            wb(0, ADR_RESULT_B, 0);
            chk(rd, {20'h0, ~q_a[$]});
            wb(1, ADR_IRQ_STAT, 3);
        end
        $display("test frames done");
        give_verdict();
    end
endmodule
